// File: core/strap_config_and_autotune_control.sv
// What this block does
// - Straps sampled only at power-up or restore
// - Direct strap decodes as low, open, high
// - Resistor strap decodes to one of 31 codes
// - Strap changes ignored until next power-up or restore
// - Bus address from strap only, writes ignored
// - Strap parameters except address writable by bus
// - Register target plus separate fault alert line
// - Setpoint from strap, writable, 0.6V to 5.5V
// - Setpoint clamped to ceiling, ceiling 110% default
// - Under limit 85%, output-ok threshold 90%
// - Margins 95%, 105%, over limit 115%
// - Tuning runs once on every output enable
// - Tuning follows ramp: test, then compute coefficients
// - Computed coefficients stored and read back
// - Tuning off: coefficients come from user store
// - Delay mode: output-ok after holdoff time
// - After-tune mode: output-ok when tuning finishes
// - Holdoff resets to 1ms, bus adjustable
// - Commands accepted after 35ms or 55ms startup
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`default_nettype none
module strap_config_and_autotune_control #(
  parameter int STARTUP_CYCLES      = strap_cfg_pkg::STARTUP_MS * strap_cfg_pkg::MS_CYCLES,
  parameter int STARTUP_TUNE_CYCLES = strap_cfg_pkg::STARTUP_TUNE_MS * strap_cfg_pkg::MS_CYCLES,
  parameter int TUNE_TEST_CYCLES    = strap_cfg_pkg::TUNE_TEST_CYCLES
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  // Avalon-MM slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Multimode straps
  input  wire logic [1:0]  i_addr_strap_kind,
  input  wire logic [4:0]  i_addr_strap_res,
  input  wire logic [1:0]  i_setpoint_strap_kind,
  input  wire logic [4:0]  i_setpoint_strap_res,
  input  wire logic [1:0]  i_tuning_strap_kind,
  input  wire logic [4:0]  i_tuning_strap_res,
  // Power stage status
  input  wire logic        i_output_enable,
  input  wire logic        i_ramp_done,
  input  wire logic [15:0] i_vout_mv,
  input  wire logic [15:0] i_plant_meas,
  // Outputs
  output logic      [6:0]  o_bus_address,
  output logic      [15:0] o_setpoint_mv,
  output logic             o_output_ok_signal,
  output logic             o_tune_busy,
  output logic             o_bus_alert_line_out,
  output logic             o_bus_alert_line_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [7:0] p);
    logic [23:0] prod;
    prod   = {8'h00, v} * {16'h0000, p};
    pct_of = 16'(prod / 24'd100);
  endfunction : pct_of

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////////
  // Strap decode

  logic [5:0] addr_idx;
  logic [5:0] sp_idx;
  logic [5:0] tune_idx;

  strap_decoder u_addr_dec (
    .i_kind     (i_addr_strap_kind),
    .i_res_code (i_addr_strap_res),
    .o_index    (addr_idx)
  );
  strap_decoder u_sp_dec (
    .i_kind     (i_setpoint_strap_kind),
    .i_res_code (i_setpoint_strap_res),
    .o_index    (sp_idx)
  );
  strap_decoder u_tune_dec (
    .i_kind     (i_tuning_strap_kind),
    .i_res_code (i_tuning_strap_res),
    .o_index    (tune_idx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        boot_q;
  logic        ready_q;
  logic [1:0]  rd_phase_q;
  logic [21:0] start_cnt_q;
  strap_cfg_pkg::tune_state_type tune_q;

  wire        hit_status  = i_avs_address == strap_cfg_pkg::OFF_STATUS;
  wire        hit_control = i_avs_address == strap_cfg_pkg::OFF_CONTROL;
  wire        hit_sp      = i_avs_address == strap_cfg_pkg::OFF_SETPOINT;
  wire        hit_ceil    = i_avs_address == strap_cfg_pkg::OFF_CEILING;
  wire        hit_under   = i_avs_address == strap_cfg_pkg::OFF_UNDER;
  wire        hit_pgood   = i_avs_address == strap_cfg_pkg::OFF_PGOOD;
  wire        hit_mlow    = i_avs_address == strap_cfg_pkg::OFF_MLOW;
  wire        hit_mhigh   = i_avs_address == strap_cfg_pkg::OFF_MHIGH;
  wire        hit_over    = i_avs_address == strap_cfg_pkg::OFF_OVER;
  wire        hit_holdoff = i_avs_address == strap_cfg_pkg::OFF_HOLDOFF;
  wire        hit_coef    = (i_avs_address >= strap_cfg_pkg::OFF_COEF0) &&
                            (i_avs_address <= strap_cfg_pkg::OFF_COEF2) &&
                            (i_avs_address[1:0] == 2'b00);
  wire [1:0]  coef_tap    = 2'(i_avs_address[3:2] - strap_cfg_pkg::OFF_COEF0[3:2]);
  wire        coef_busy   = hit_coef && i_avs_write && (tune_q == strap_cfg_pkg::TUNE_COMPUTE);
  wire        bus_wait    = !ready_q || coef_busy ||
                            (i_avs_read && rd_phase_q != 2'd2);
  wire        wr_en       = i_clk_en && i_avs_write && !bus_wait;
  wire        restore     = wr_en && hit_control &&
                            i_avs_writedata[strap_cfg_pkg::CTL_RESTORE_BIT] &&
                            i_avs_byteenable[0];
  wire        load        = i_clk_en && (boot_q || restore);

  assign o_avs_waitrequest = bus_wait;

  ////////////////////////////////////////////////////////////////////////////////
  // Startup gate

  logic tune_en_q;

  wire [21:0] start_target = tune_en_q ? 22'(STARTUP_TUNE_CYCLES) : 22'(STARTUP_CYCLES);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_q      <= 1'b1;
      ready_q     <= 1'b0;
      start_cnt_q <= '0;
    end else if (i_clk_en) begin
      boot_q      <= 1'b0;
      start_cnt_q <= ready_q ? start_cnt_q : 22'(start_cnt_q + 22'd1);
      ready_q     <= ready_q || (!boot_q && start_cnt_q >= start_target);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [5:0]  addr_idx_q;
  logic [5:0]  sp_idx_q;
  logic [5:0]  tune_idx_q;
  logic [15:0] setpoint_q;
  logic [15:0] ceiling_q;
  logic [15:0] under_q;
  logic [15:0] pgood_q;
  logic [15:0] mlow_q;
  logic [15:0] mhigh_q;
  logic [15:0] over_q;
  logic [15:0] holdoff_q;
  logic        pg_after_tune_q;

  wire [15:0] sp_strap  = 16'(strap_cfg_pkg::SETPOINT_MIN_MV +
                          16'({10'h000, sp_idx} * strap_cfg_pkg::SETPOINT_STEP_MV));
  wire [15:0] sp_hi     = (ceiling_q < strap_cfg_pkg::SETPOINT_MAX_MV) ?
                          ceiling_q : strap_cfg_pkg::SETPOINT_MAX_MV;
  wire [15:0] sp_wr     = merge16(setpoint_q, i_avs_writedata, i_avs_byteenable);
  wire [15:0] setpoint_d = (sp_wr > sp_hi) ? sp_hi :
                           (sp_wr < strap_cfg_pkg::SETPOINT_MIN_MV) ?
                           strap_cfg_pkg::SETPOINT_MIN_MV : sp_wr;

  // Strap selections, held until next load
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_idx_q <= '0;
      sp_idx_q   <= '0;
      tune_idx_q <= '0;
    end else if (load) begin
      addr_idx_q <= addr_idx;
      sp_idx_q   <= sp_idx;
      tune_idx_q <= tune_idx;
    end
  end

  // Setpoint and ceiling
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      setpoint_q <= strap_cfg_pkg::SETPOINT_MIN_MV;
      ceiling_q  <= strap_cfg_pkg::SETPOINT_MAX_MV;
    end else if (load) begin
      setpoint_q <= sp_strap;
      ceiling_q  <= pct_of(sp_strap, strap_cfg_pkg::PCT_CEILING);
    end else if (wr_en && hit_sp) begin
      setpoint_q <= setpoint_d;
    end else if (wr_en && hit_ceil) begin
      ceiling_q  <= merge16(ceiling_q, i_avs_writedata, i_avs_byteenable);
    end
  end

  // Derived limits; bus writes stored as given
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      under_q <= '0;
      pgood_q <= '0;
      mlow_q  <= '0;
      mhigh_q <= '0;
      over_q  <= '0;
    end else if (load) begin
      under_q <= pct_of(sp_strap, strap_cfg_pkg::PCT_UNDER);
      pgood_q <= pct_of(sp_strap, strap_cfg_pkg::PCT_PGOOD);
      mlow_q  <= pct_of(sp_strap, strap_cfg_pkg::PCT_MLOW);
      mhigh_q <= pct_of(sp_strap, strap_cfg_pkg::PCT_MHIGH);
      over_q  <= pct_of(sp_strap, strap_cfg_pkg::PCT_OVER);
    end else if (wr_en) begin
      under_q <= hit_under ? merge16(under_q, i_avs_writedata, i_avs_byteenable) : under_q;
      pgood_q <= hit_pgood ? merge16(pgood_q, i_avs_writedata, i_avs_byteenable) : pgood_q;
      mlow_q  <= hit_mlow ? merge16(mlow_q, i_avs_writedata, i_avs_byteenable) : mlow_q;
      mhigh_q <= hit_mhigh ? merge16(mhigh_q, i_avs_writedata, i_avs_byteenable) : mhigh_q;
      over_q  <= hit_over ? merge16(over_q, i_avs_writedata, i_avs_byteenable) : over_q;
    end
  end

  // Holdoff and mode controls
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      holdoff_q       <= strap_cfg_pkg::HOLDOFF_US_RESET;
      tune_en_q       <= 1'b0;
      pg_after_tune_q <= 1'b0;
    end else if (load) begin
      holdoff_q       <= strap_cfg_pkg::HOLDOFF_US_RESET;
      tune_en_q       <= tune_idx != 6'h00;
    end else if (wr_en && hit_holdoff) begin
      holdoff_q       <= merge16(holdoff_q, i_avs_writedata, i_avs_byteenable);
    end else if (wr_en && hit_control && i_avs_byteenable[0]) begin
      tune_en_q       <= i_avs_writedata[strap_cfg_pkg::CTL_TUNE_EN_BIT];
      pg_after_tune_q <= i_avs_writedata[strap_cfg_pkg::CTL_PG_MODE_BIT];
    end
  end

  assign o_bus_address = 7'(strap_cfg_pkg::BUS_ADDR_BASE + {1'b0, addr_idx_q});
  assign o_setpoint_mv = setpoint_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Tuning sequencer

  coef_mem_if #(.DW(16), .AW(3)) cmem ();

  coef_store #(.DW(16), .AW(3)) u_coef_store (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_clk_en   (i_clk_en),
    .port       (cmem.mem)
  );

  logic        ramp_q;
  logic [15:0] test_cnt_q;
  logic [1:0]  tap_q;
  logic [15:0] meas_q;

  wire ramp_rise  = i_ramp_done && !ramp_q;
  wire tune_start = tune_en_q && i_output_enable && ramp_rise;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tune_q     <= strap_cfg_pkg::TUNE_IDLE;
      ramp_q     <= 1'b0;
      test_cnt_q <= '0;
      tap_q      <= '0;
      meas_q     <= '0;
    end else if (i_clk_en) begin
      ramp_q <= i_ramp_done;
      unique case (tune_q)
        strap_cfg_pkg::TUNE_IDLE: begin
          test_cnt_q <= '0;
          tap_q      <= '0;
          tune_q     <= tune_start ? strap_cfg_pkg::TUNE_TEST : strap_cfg_pkg::TUNE_IDLE;
        end
        strap_cfg_pkg::TUNE_TEST: begin
          test_cnt_q <= 16'(test_cnt_q + 16'd1);
          meas_q     <= i_plant_meas;
          if (!i_output_enable) begin
            tune_q <= strap_cfg_pkg::TUNE_IDLE;
          end else if (test_cnt_q == 16'(TUNE_TEST_CYCLES - 1)) begin
            tune_q <= strap_cfg_pkg::TUNE_COMPUTE;
          end
        end
        strap_cfg_pkg::TUNE_COMPUTE: begin
          tap_q  <= 2'(tap_q + 2'd1);
          tune_q <= (tap_q == 2'(strap_cfg_pkg::COEF_TAPS - 1)) ?
                    strap_cfg_pkg::TUNE_DONE : strap_cfg_pkg::TUNE_COMPUTE;
        end
        strap_cfg_pkg::TUNE_DONE: begin
          tune_q <= i_output_enable ? strap_cfg_pkg::TUNE_DONE : strap_cfg_pkg::TUNE_IDLE;
        end
      endcase
    end
  end

  // Bank 1 holds tuning results, bank 0 the user store
  wire computing = tune_q == strap_cfg_pkg::TUNE_COMPUTE;
  assign cmem.we    = i_clk_en && (computing || (wr_en && hit_coef));
  assign cmem.waddr = computing ? {1'b1, tap_q} : {1'b0, coef_tap};
  assign cmem.wdata = computing ? 16'(meas_q >> tap_q) :
                      merge16(16'h0000, i_avs_writedata, i_avs_byteenable);
  assign cmem.raddr = {tune_en_q, coef_tap};
  assign o_tune_busy = (tune_q == strap_cfg_pkg::TUNE_TEST) || computing;

  ////////////////////////////////////////////////////////////////////////////////
  // Output-ok and alert

  logic        ok_q;
  logic        alert_q;
  logic [5:0]  us_pre_q;
  logic [15:0] us_cnt_q;

  wire fault     = i_output_enable && i_ramp_done &&
                   ((i_vout_mv > over_q) || (i_vout_mv < under_q));
  wire cond      = i_output_enable && i_ramp_done && (i_vout_mv >= pgood_q) && !fault;
  wire after_mode = pg_after_tune_q && tune_en_q;
  wire us_tick   = us_pre_q == 6'(strap_cfg_pkg::US_CYCLES - 1);
  wire ok_d      = cond && (after_mode ? (tune_q == strap_cfg_pkg::TUNE_DONE) :
                                         (us_cnt_q >= holdoff_q));
  wire alert_clr = wr_en && hit_status && i_avs_byteenable[0] &&
                   i_avs_writedata[strap_cfg_pkg::ST_ALERT_BIT];

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      us_pre_q <= '0;
      us_cnt_q <= '0;
    end else if (i_clk_en) begin
      us_pre_q <= (!cond || us_tick) ? 6'h00 : 6'(us_pre_q + 6'd1);
      us_cnt_q <= !cond ? 16'h0000 :
                  (us_tick && us_cnt_q != 16'hFFFF) ? 16'(us_cnt_q + 16'd1) : us_cnt_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ok_q    <= 1'b0;
      alert_q <= 1'b0;
    end else if (i_clk_en) begin
      ok_q    <= ok_d;
      alert_q <= fault || (alert_q && !alert_clr);
    end
  end

  assign o_output_ok_signal   = ok_q;
  assign o_bus_alert_line_out = 1'b0;
  assign o_bus_alert_line_oe  = alert_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  wire [31:0] status_word = {2'b00, tune_idx_q, 2'b00, sp_idx_q, 2'b00, addr_idx_q, 3'b000,
                             alert_q, ok_q, tune_q == strap_cfg_pkg::TUNE_DONE,
                             o_tune_busy, ready_q};
  wire [31:0] control_word = {29'h0, pg_after_tune_q, tune_en_q, 1'b0};

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_status)  rd_mux = status_word;
    if (hit_control) rd_mux = control_word;
    if (i_avs_address == strap_cfg_pkg::OFF_BUS_ADDR) rd_mux = {25'h0, o_bus_address};
    if (hit_sp)      rd_mux = {16'h0, setpoint_q};
    if (hit_ceil)    rd_mux = {16'h0, ceiling_q};
    if (hit_under)   rd_mux = {16'h0, under_q};
    if (hit_pgood)   rd_mux = {16'h0, pgood_q};
    if (hit_mlow)    rd_mux = {16'h0, mlow_q};
    if (hit_mhigh)   rd_mux = {16'h0, mhigh_q};
    if (hit_over)    rd_mux = {16'h0, over_q};
    if (hit_holdoff) rd_mux = {16'h0, holdoff_q};
    if (hit_coef)    rd_mux = {16'h0, cmem.rdata};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_phase_q     <= '0;
      o_avs_readdata <= '0;
    end else if (i_clk_en) begin
      rd_phase_q     <= (!i_avs_read || !ready_q || rd_phase_q == 2'd2) ? 2'd0 :
                        2'(rd_phase_q + 2'd1);
      o_avs_readdata <= (rd_phase_q == 2'd1) ? rd_mux : o_avs_readdata;
    end
  end

endmodule : strap_config_and_autotune_control
`default_nettype wire

// File: core/strap_cfg_pkg.sv
`default_nettype none
package strap_cfg_pkg;

  // Timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int MS_CYCLES        = CLK_HZ / 1000;
  localparam int US_CYCLES        = CLK_HZ / 1_000_000;
  localparam int STARTUP_MS       = 35;
  localparam int STARTUP_TUNE_MS  = 55;
  localparam int TUNE_TEST_CYCLES = 64;
  localparam logic [15:0] HOLDOFF_US_RESET = 16'h03E8;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CONTROL  = 8'h04;
  localparam logic [7:0] OFF_BUS_ADDR = 8'h08;
  localparam logic [7:0] OFF_SETPOINT = 8'h0C;
  localparam logic [7:0] OFF_CEILING  = 8'h10;
  localparam logic [7:0] OFF_UNDER    = 8'h14;
  localparam logic [7:0] OFF_PGOOD    = 8'h18;
  localparam logic [7:0] OFF_MLOW     = 8'h1C;
  localparam logic [7:0] OFF_MHIGH    = 8'h20;
  localparam logic [7:0] OFF_OVER     = 8'h24;
  localparam logic [7:0] OFF_HOLDOFF  = 8'h28;
  localparam logic [7:0] OFF_COEF0    = 8'h30;
  localparam logic [7:0] OFF_COEF2    = 8'h38;

  // Field positions
  localparam int CTL_RESTORE_BIT  = 0;
  localparam int CTL_TUNE_EN_BIT  = 1;
  localparam int CTL_PG_MODE_BIT  = 2;
  localparam int ST_READY_BIT     = 0;
  localparam int ST_TUNE_BUSY_BIT = 1;
  localparam int ST_TUNE_DONE_BIT = 2;
  localparam int ST_OUT_OK_BIT    = 3;
  localparam int ST_ALERT_BIT     = 4;
  localparam int ST_ADDR_IDX_LSB  = 8;
  localparam int ST_SP_IDX_LSB    = 16;
  localparam int ST_TUNE_IDX_LSB  = 24;

  // Setpoint and limit arithmetic
  localparam logic [15:0] SETPOINT_MIN_MV  = 16'h0258;
  localparam logic [15:0] SETPOINT_MAX_MV  = 16'h157C;
  localparam logic [15:0] SETPOINT_STEP_MV = 16'h0032;
  localparam logic [7:0]  PCT_CEILING      = 8'h6E;
  localparam logic [7:0]  PCT_UNDER        = 8'h55;
  localparam logic [7:0]  PCT_PGOOD        = 8'h5A;
  localparam logic [7:0]  PCT_MLOW         = 8'h5F;
  localparam logic [7:0]  PCT_MHIGH        = 8'h69;
  localparam logic [7:0]  PCT_OVER         = 8'h73;
  localparam logic [6:0]  BUS_ADDR_BASE    = 7'h20;

  // Strap decoding
  localparam logic [4:0] RES_CODE_MAX = 5'h1E;
  localparam logic [5:0] RES_IDX_BASE = 6'h03;

  typedef enum logic [1:0] {
    STRAP_LOW  = 2'b00,
    STRAP_OPEN = 2'b01,
    STRAP_HIGH = 2'b10,
    STRAP_RES  = 2'b11
  } strap_kind_type;

  typedef enum logic [1:0] {
    TUNE_IDLE    = 2'b00,
    TUNE_TEST    = 2'b01,
    TUNE_COMPUTE = 2'b10,
    TUNE_DONE    = 2'b11
  } tune_state_type;

  localparam int COEF_TAPS = 3;

endpackage : strap_cfg_pkg
`default_nettype wire

// File: core/coef_mem_if.sv
`default_nettype none
interface coef_mem_if #(
  parameter int DW = 16,
  parameter int AW = 3
) ();
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : coef_mem_if
`default_nettype wire

// File: core/coef_store.sv
`default_nettype none
module coef_store #(
  parameter int DW = 16,
  parameter int AW = 3
) (
  // Clock
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clk_en,
  // Access
  coef_mem_if.mem   port
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port.rdata <= '0;
    end else if (i_clk_en) begin
      port.rdata <= mem_q[port.raddr];
    end
  end

endmodule : coef_store
`default_nettype wire

// File: core/strap_decoder.sv
`default_nettype none
module strap_decoder (
  // Sampled pin
  input  wire logic [1:0] i_kind,
  input  wire logic [4:0] i_res_code,
  // Selection
  output logic      [5:0] o_index
);

  // Three direct levels, then resistor codes
  wire [4:0] res_sat = (i_res_code > strap_cfg_pkg::RES_CODE_MAX) ?
                       strap_cfg_pkg::RES_CODE_MAX : i_res_code;

  always_comb begin
    unique case (strap_cfg_pkg::strap_kind_type'(i_kind))
      strap_cfg_pkg::STRAP_LOW:  o_index = 6'h00;
      strap_cfg_pkg::STRAP_OPEN: o_index = 6'h01;
      strap_cfg_pkg::STRAP_HIGH: o_index = 6'h02;
      strap_cfg_pkg::STRAP_RES:  o_index = strap_cfg_pkg::RES_IDX_BASE + {1'b0, res_sat};
    endcase
  end

endmodule : strap_decoder
`default_nettype wire

// File: bench/strap_cfg_checker.sv
`default_nettype none
module strap_cfg_checker #(parameter int TUNE_TEST_CYCLES = 4) (
  // Watched ports
  input wire logic        i_core_clk, i_rst_b, i_avs_read, i_avs_write, o_avs_waitrequest,
  input wire logic        i_output_enable, i_ramp_done, o_tune_busy, o_output_ok_signal,
  input wire logic        o_bus_alert_line_out, o_bus_alert_line_oe,
  input wire logic [7:0]  i_avs_address,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [6:0]  o_bus_address,
  input wire logic [15:0] o_setpoint_mv
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [3:0] live_q;
  logic [7:0] busy_q;
  logic [2:0] rs_q;
  wire acc = i_avs_write && !o_avs_waitrequest;
  wire rs  = acc && i_avs_address == 8'h04 && i_avs_writedata[0];
  wire lo  = acc && i_avs_address == 8'h0C && i_avs_writedata[15:0] < 16'h0258;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      live_q <= 4'h0;
      busy_q <= 8'h00;
      rs_q   <= 3'h0;
    end else begin
      live_q <= {live_q[2:0], 1'b1};
      busy_q <= o_tune_busy ? busy_q + 8'h01 : 8'h00;
      rs_q   <= {rs_q[1:0], rs};
    end
  end
  ////////////////////////////////////////////////////////////////////
  sequence s_rd_hold; o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
  property p_rd_wait; $rose(i_avs_read) |-> s_rd_hold; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answered early");
  property p_sp_range; o_setpoint_mv >= 16'h0258 && o_setpoint_mv <= 16'h157C; endproperty
  a_sp_range: assert property (p_sp_range) else $error("setpoint out of span");
  property p_sp_floor; lo |=> o_setpoint_mv == 16'h0258; endproperty
  a_sp_floor: assert property (p_sp_floor) else $error("low setpoint kept");
  property p_addr_cause; live_q[3] && $changed(o_bus_address) |-> |rs_q; endproperty
  a_addr_cause: assert property (p_addr_cause) else $error("address moved");
  property p_busy_len; $fell(o_tune_busy) |-> busy_q >= TUNE_TEST_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("tuning run short");
  property p_ok_cause;
    o_output_ok_signal |-> $past(i_output_enable) && $past(i_ramp_done);
  endproperty
  a_ok_cause: assert property (p_ok_cause) else $error("output ok early");
  property p_alert_cause; $rose(o_bus_alert_line_oe) |-> $past(i_ramp_done); endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without fault");
  property p_alert_low; o_bus_alert_line_out == 1'b0; endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert drives high");
endmodule : strap_cfg_checker
bind strap_config_and_autotune_control strap_cfg_checker #(
  .TUNE_TEST_CYCLES(TUNE_TEST_CYCLES)
) u_chk (.*);
`default_nettype wire

// File: bench/power_stage_model.sv
`default_nettype none
module power_stage_model #(parameter int RAMP = 10) (
  // Controls
  input  wire logic        i_core_clk, i_enable, i_fault,
  input  wire logic [15:0] i_target_mv,
  // Status
  output logic             o_ramp_done,
  output logic      [15:0] o_vout_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge i_core_clk) cnt <= !i_enable ? 0 : cnt + ((cnt < RAMP) ? 1 : 0);
  assign o_ramp_done = cnt == RAMP;
  assign o_vout_mv = i_fault ? 16'h1F40 : o_ramp_done ? i_target_mv : i_target_mv >> 1;
endmodule : power_stage_model
`default_nettype wire

// File: bench/strap_config_and_autotune_control_tb.sv
`default_nettype none
module strap_config_and_autotune_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic i_output_enable = 1'b0, flt = 1'b0, i_clk_en = 1'b1, i_ramp_done, o_avs_waitrequest;
  logic o_output_ok_signal, o_tune_busy, o_bus_alert_line_out, o_bus_alert_line_oe;
  logic [1:0] i_addr_strap_kind = 2'h3, i_setpoint_strap_kind = 2'h2, i_tuning_strap_kind = 2'h2;
  logic [4:0] i_addr_strap_res = 5'h05, i_setpoint_strap_res = 5'h00, i_tuning_strap_res = 5'h00;
  logic [7:0] i_avs_address = 8'h00;
  logic [6:0] o_bus_address;
  logic [15:0] i_plant_meas = 16'h0000, i_vout_mv, o_setpoint_mv;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, v, seed = 32'h0000143A, q[$];
  logic [31:0] exps[6] = '{32'h302, 32'h253, 32'h276, 32'h299, 32'h2DF, 32'h325};
  int fail_count = 0, num_checks = 0, n;
  always #10 i_core_clk = ~i_core_clk;
  strap_config_and_autotune_control #(
    .STARTUP_CYCLES(20), .STARTUP_TUNE_CYCLES(30), .TUNE_TEST_CYCLES(4)
  ) DUT (.i_avs_byteenable(4'hF), .*);
  power_stage_model #(.RAMP(10)) u_stage (.i_core_clk, .i_enable(i_output_enable),
    .i_fault(flt), .i_target_mv(o_setpoint_mv), .o_ramp_done(i_ramp_done), .o_vout_mv(i_vout_mv));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic await_busy(input logic lvl);
    n = 0;
    while (o_tune_busy !== lvl && n < 200) begin
      @(posedge i_core_clk);
      n++;
    end
    check(o_tune_busy, lvl);
  endtask : await_busy
  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // Read monitor
  always @(posedge i_core_clk) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0) check(o_avs_readdata, q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge i_core_clk);
    fail_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (34) @(posedge i_core_clk);
    check(o_bus_address, 32'h28);
    check(o_setpoint_mv, 32'h2BC);
    rd(8'h28, 32'h3E8);
    for (int i = 0; i < 6; i++) rd(8'h10 + 8'(4 * i), exps[i]);
    v = rnd();
    i_addr_strap_kind <= 2'h1;
    i_setpoint_strap_kind <= 2'h0;
    i_setpoint_strap_res <= v[4:0];
    i_tuning_strap_res <= v[9:5];
    bus(1'b1, 8'h08, v);
    repeat (3) @(posedge i_core_clk);
    check(o_bus_address, 32'h28);
    repeat (8) begin
      v = 32'h200 + rnd() % 32'h140;
      bus(1'b1, 8'h0C, v);
      rd(8'h0C, v < 32'h258 ? 32'h258 : v > 32'h302 ? 32'h302 : v);
    end
    bus(1'b1, 8'h14, 32'h400);
    rd(8'h14, 32'h400);
    bus(1'b1, 8'h04, 32'h1);
    repeat (4) @(posedge i_core_clk);
    check(o_bus_address, 32'h21);
    check(o_setpoint_mv, 32'h258);
    rd(8'h10, 32'h294);
    bus(1'b1, 8'h04, 32'h6);
    for (int t = 0; t < 2; t++) begin
      v = rnd();
      i_plant_meas <= v[15:0];
      i_output_enable <= 1'b1;
      await_busy(1'b1);
      await_busy(1'b0);
      repeat (2) @(posedge i_core_clk);
      check(o_output_ok_signal, 32'h1);
      for (int k = 0; k < 3; k++) rd(8'h30 + 8'(4 * k), {16'h0, v[15:0] >> k});
      i_output_enable <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      check(o_output_ok_signal, 32'h0);
    end
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h28, 32'h2);
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      bus(1'b1, 8'h30 + 8'(4 * k), v);
      rd(8'h30 + 8'(4 * k), {16'h0, v[15:0]});
    end
    i_output_enable <= 1'b1;
    repeat (60) @(posedge i_core_clk);
    check(o_output_ok_signal, 32'h0);
    i_clk_en <= 1'b0;
    repeat (150) @(posedge i_core_clk);
    check(o_output_ok_signal, 32'h0);
    i_clk_en <= 1'b1;
    repeat (140) @(posedge i_core_clk);
    check(o_output_ok_signal, 32'h1);
    flt <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    check(o_bus_alert_line_oe, 32'h1);
    flt <= 1'b0;
    bus(1'b1, 8'h00, 32'h10);
    repeat (2) @(posedge i_core_clk);
    check(o_bus_alert_line_oe, 32'h0);
    print_verdict();
  end
endmodule : strap_config_and_autotune_control_tb
`default_nettype wire
